// ### srro_pkg.sv
// Constants and types for the scan result raw output block
package srro_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_BCNT = 8'h04;
    localparam logic [7:0] A_SER = 8'h08;
    localparam logic [7:0] A_SEE = 8'h0C;
    localparam logic [7:0] A_ESR = 8'h10;
    localparam logic [7:0] A_ERR = 8'h14;
    localparam logic [7:0] A_CMD = 8'h18;
    localparam logic [7:0] A_DATA = 8'h1C;
    localparam int MEM_DEPTH = 30000;
    localparam int TMP_DEPTH = 512;
    localparam int TOT_DEPTH = MEM_DEPTH + TMP_DEPTH;
    localparam int PW = 15;
    localparam int Q_DEPTH = 4;
    localparam logic [PW-1:0] TOT_CNT = PW'(TOT_DEPTH);
    localparam logic [PW-1:0] MAX_BCNT = 15'h7530;
    localparam logic [PW-1:0] BCNT_RST = 15'h0064;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:0] SEE_RST = 8'h00;
    localparam int CT_SYNC = 0;
    localparam int CT_DUAL = 3;
    localparam logic [1:0] EL_BAD = 2'h3;
    localparam int SE_LAST = 2;
    localparam int SE_VAL = 5;
    localparam int SE_SECOND_DETECTOR_SELECT = 6;
    localparam int SE_FIRST_DETECTOR_SELECT = 7;
    localparam int ES_QRY = 2;
    localparam int ES_DEV = 3;
    localparam int ES_EXE = 4;
    localparam int ES_CMD = 5;
    localparam int C_QUERY = 0;
    localparam int C_REPLAY = 1;
    localparam int C_CLS = 2;
    localparam int C_RST = 3;
    localparam int C_START = 4;
    localparam int C_STOP = 5;
    localparam int C_PLOT = 6;
    localparam logic [15:0] E_NONE = 16'h0000;
    localparam logic [15:0] E_UNKNOWN = 16'hFF8F;
    localparam logic [15:0] E_RANGE = 16'hFF22;
    localparam logic [15:0] E_OVERFLOW = 16'hFE70;
    localparam logic [15:0] E_NODATA = 16'hFE5C;
    typedef enum logic [1:0] {
        CIC_IDLE = 2'b00,
        CIC_WAIT = 2'b01,
        CIC_SELF = 2'b10,
        CIC_PASS = 2'b11
    } srro_cic_e;
endpackage

// ### srro_top.sv
// Scan result raw output engine with APB registers
`timescale 1ns/1ps
`default_nettype none
module srro_top
    import srro_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_valid,
    input wire logic [15:0] meas_lvl1,
    input wire logic [15:0] meas_lvl2,
    input wire logic [7:0] meas_vbyte,
    output logic scan_stall,
    output logic scan_active,
    output logic srq,
    input wire logic dev_err,
    input wire logic [7:0] dev_code,
    input wire logic atn_in,
    output logic atn_out,
    output logic atn_oe,
    input wire logic talk_in,
    input wire logic plot_done,
    output logic plot_start,
    output logic pass_back,
    output logic cic
);
    logic setup, acc, wr, rd, mapped, cmd_w;
    logic q_cmd, rp_cmd, cls_cmd, rst_cmd, go_cmd, halt_cmd, plot_cmd;
    logic data_rd, pop, nodata, qry_none, ovf, unk, bcnt_bad, sel_bad;
    logic qry_err, exe_err, err_any, store, lastc, all_empty;
    logic [15:0] err_code, rdval;
    logic [1:0] sel;
    logic [3:0] ctrl, next_ctrl;
    logic [PW-1:0] bcnt, next_bcnt, wp, next_wp, nst, next_nst;
    logic [PW-1:0] blk, next_blk;
    logic [7:0] ser, next_ser, see, next_see, esr, next_esr;
    logic [31:0] next_prdata;
    logic next_pslverr, next_srq, next_stall, next_scan;
    logic last_q;
    wire [2:0][PW-1:0] rpv;
    wire [2:0][PW-1:0] cntv;
    wire [2:0] act;
    wire [2:0] rdy;
    wire [2:0] dn;
    logic [15:0] mem1 [TOT_DEPTH];
    logic [15:0] mem2 [TOT_DEPTH];
    logic [7:0] memv [TOT_DEPTH];
    logic [15:0] eq [Q_DEPTH];
    logic [1:0] eq_head, next_head;
    logic [2:0] eq_cnt, next_eqcnt;
    logic eq_pop, eq_push;
    srro_cic_e st, next_st;
    logic plot_pend, next_pend, atn_seen, next_seen;
    logic next_pstart, next_pback;
    logic [1:0] sy0, sy1, sy2, pf, next_pf;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign setup = psel & ~penable;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= A_DATA);
    assign cmd_w = wr && (paddr == A_CMD);
    assign q_cmd = cmd_w & pwdata[C_QUERY];
    assign rp_cmd = cmd_w & pwdata[C_REPLAY];
    assign cls_cmd = cmd_w & pwdata[C_CLS];
    assign rst_cmd = cmd_w & pwdata[C_RST];
    assign go_cmd = cmd_w & pwdata[C_START];
    assign halt_cmd = cmd_w & pwdata[C_STOP];
    assign plot_cmd = cmd_w & pwdata[C_PLOT];
    assign sel = ctrl[2:1];
    assign data_rd = rd && (paddr == A_DATA);
    assign pop = data_rd && (blk != 15'h0000);
    assign nodata = data_rd && (blk == 15'h0000);
    assign qry_none = q_cmd && (cntv[sel] == 15'h0000);
    // A second query while a block is open would overrun the output
    assign ovf = q_cmd && (blk != 15'h0000);
    assign unk = acc && !mapped;
    assign bcnt_bad = wr && (paddr == A_BCNT)
        && (pwdata > {17'h00000, MAX_BCNT});
    assign sel_bad = wr && (paddr == A_CTRL) && (pwdata[2:1] == EL_BAD);
    assign qry_err = nodata | qry_none | ovf;
    assign exe_err = bcnt_bad | sel_bad;
    assign err_any = unk | exe_err | qry_err | dev_err;
    assign store = meas_valid & scan_active & ~scan_stall;
    assign all_empty = &(dn | ~act);
    assign lastc = !scan_active && (nst != 15'h0000)
        && (ctrl[CT_SYNC] ? all_empty : |dn);

    // Per result type read pointer and count of unfetched values
    generate
        for (genvar t = 0; t < 3; t++)
        begin : g_type
            logic [PW-1:0] rp, cnt, next_rp, next_cnt;
            logic popt, putt;
            assign act[t] = (t != 1) || ctrl[CT_DUAL];
            assign popt = pop && (sel == 2'(t));
            assign putt = store && act[t];
            assign rpv[t] = rp;
            assign cntv[t] = cnt;
            assign dn[t] = act[t] && (cnt == 15'h0000);
            assign rdy[t] = act[t] && (cnt != 15'h0000)
                && (!scan_active || scan_stall || rp_cmd || q_cmd
                || ((bcnt != 15'h0000) && (cnt >= bcnt)));
            always_comb
            begin
                next_rp = rp;
                next_cnt = cnt;
                if (go_cmd)
                begin
                    next_rp = 15'h0000;
                    next_cnt = 15'h0000;
                end
                else if (rp_cmd)
                begin
                    // Values past the wrap point are lost to a replay
                    next_rp = 15'h0000;
                    next_cnt = act[t] ? nst : 15'h0000;
                end
                else
                begin
                    if (popt)
                        next_rp = (rp == TOT_CNT - 15'h0001) ? 15'h0000
                            : rp + 15'h0001;
                    next_cnt = cnt + PW'(putt) - PW'(popt);
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    rp <= 15'h0000;
                    cnt <= 15'h0000;
                end
                else
                begin
                    rp <= next_rp;
                    cnt <= next_cnt;
                end
            end
        end
    endgenerate

    // Separate memories; the top TMP_DEPTH words act as overflow space
    always_ff @(posedge pclk)
    begin
        if (store)
        begin
            mem1[wp] <= meas_lvl1;
            mem2[wp] <= meas_lvl2;
            memv[wp] <= meas_vbyte;
        end
    end

    // Raw value, no header, selected memory only
    always_comb
    begin
        unique case (sel)
            2'h0: rdval = mem1[rpv[0]];
            2'h1: rdval = mem2[rpv[1]];
            2'h2: rdval = {8'h00, memv[rpv[2]]};
            default: rdval = 16'h0000;
        endcase
    end

    always_comb
    begin
        next_ctrl = ctrl;
        next_bcnt = bcnt;
        next_see = see;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (wr && (paddr == A_CTRL) && !sel_bad)
            next_ctrl = pwdata[3:0];
        if (wr && (paddr == A_BCNT) && !bcnt_bad)
            next_bcnt = pwdata[PW-1:0];
        if (wr && (paddr == A_SEE))
            next_see = pwdata[7:0];
        if (rst_cmd)
        begin
            next_ctrl = CTRL_RST;
            next_bcnt = BCNT_RST;
            next_see = SEE_RST;
        end
        // Read data is prepared in the setup cycle for a zero wait answer
        if (setup)
        begin
            next_pslverr = !mapped;
            case (paddr)
                A_CTRL: next_prdata = {28'h0000000, ctrl};
                A_BCNT: next_prdata = {17'h00000, bcnt};
                A_SER: next_prdata = {24'h000000, ser};
                A_SEE: next_prdata = {24'h000000, see};
                A_ESR: next_prdata = {24'h000000, esr};
                A_ERR: next_prdata = (eq_cnt != 3'h0)
                    ? {{16{eq[eq_head][15]}}, eq[eq_head]}
                    : {16'h0000, E_NONE};
                A_DATA: next_prdata = (blk != 15'h0000)
                    ? {16'h0000, rdval} : 32'h00000000;
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RST;
            bcnt <= BCNT_RST;
            see <= SEE_RST;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            bcnt <= next_bcnt;
            see <= next_see;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            pready <= 1'b1;
        end
    end

    always_comb
    begin
        next_wp = wp;
        next_nst = nst;
        next_blk = blk;
        next_scan = scan_active;
        next_stall = scan_stall;
        next_ser = ser;
        next_srq = |(ser & see);
        if (go_cmd)
        begin
            next_wp = 15'h0000;
            next_nst = 15'h0000;
            next_blk = 15'h0000;
            next_scan = 1'b1;
            next_stall = 1'b0;
        end
        else
        begin
            if (store)
            begin
                next_wp = (wp == TOT_CNT - 15'h0001) ? 15'h0000
                    : wp + 15'h0001;
                if (nst != TOT_CNT)
                    next_nst = nst + 15'h0001;
            end
            if (halt_cmd || rst_cmd)
                next_scan = 1'b0;
            if (rp_cmd)
                next_blk = 15'h0000;
            else if (q_cmd && !ovf && !qry_none)
                next_blk = ((bcnt == 15'h0000) || (bcnt > cntv[sel]))
                    ? cntv[sel] : bcnt;
            else if (pop)
                next_blk = blk - 15'h0001;
            if (!scan_active || all_empty)
                next_stall = 1'b0;
            else if ((cntv[0] == TOT_CNT) || ((bcnt != 15'h0000)
                && (cntv[0] >= bcnt)))
                next_stall = 1'b1;
        end
        // Hardware sets win over the clear on read
        if (rd && (paddr == A_SER))
            next_ser = 8'h00;
        next_ser[SE_FIRST_DETECTOR_SELECT] = next_ser[SE_FIRST_DETECTOR_SELECT] | rdy[0];
        next_ser[SE_SECOND_DETECTOR_SELECT] = next_ser[SE_SECOND_DETECTOR_SELECT] | rdy[1];
        next_ser[SE_VAL] = next_ser[SE_VAL] | rdy[2];
        if (lastc && !last_q)
            next_ser[SE_LAST] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp <= 15'h0000;
            nst <= 15'h0000;
            blk <= 15'h0000;
            scan_active <= 1'b0;
            scan_stall <= 1'b0;
            ser <= 8'h00;
            last_q <= 1'b0;
            srq <= 1'b0;
        end
        else
        begin
            wp <= next_wp;
            nst <= next_nst;
            blk <= next_blk;
            scan_active <= next_scan;
            scan_stall <= next_stall;
            ser <= next_ser;
            last_q <= lastc;
            srq <= next_srq;
        end
    end

    // Error status and code queue; one code per cycle, first cause wins
    always_comb
    begin
        if (unk)
            err_code = E_UNKNOWN;
        else if (exe_err)
            err_code = E_RANGE;
        else if (ovf)
            err_code = E_OVERFLOW;
        else if (qry_err)
            err_code = E_NODATA;
        else
            err_code = {8'h00, dev_code};
        eq_pop = rd && (paddr == A_ERR) && (eq_cnt != 3'h0);
        eq_push = err_any && ((eq_cnt != 3'(Q_DEPTH)) || eq_pop
            || cls_cmd || rst_cmd);
        next_head = eq_pop ? eq_head + 2'h1 : eq_head;
        next_eqcnt = eq_cnt + 3'(eq_push) - 3'(eq_pop);
        next_esr = esr;
        if ((rd && (paddr == A_ESR)) || cls_cmd || rst_cmd)
            next_esr = 8'h00;
        if (cls_cmd || rst_cmd)
        begin
            // A code raised in the clearing cycle survives the clear
            next_head = 2'h0;
            next_eqcnt = 3'(eq_push);
        end
        next_esr[ES_QRY] = next_esr[ES_QRY] | qry_err;
        next_esr[ES_DEV] = next_esr[ES_DEV] | dev_err;
        next_esr[ES_EXE] = next_esr[ES_EXE] | exe_err;
        next_esr[ES_CMD] = next_esr[ES_CMD] | unk;
    end

    always_ff @(posedge pclk)
    begin
        if (eq_push)
            eq[(cls_cmd || rst_cmd) ? 2'h0 : 2'(eq_head + eq_cnt[1:0])]
                <= err_code;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            esr <= 8'h00;
            eq_head <= 2'h0;
            eq_cnt <= 3'h0;
        end
        else
        begin
            esr <= next_esr;
            eq_head <= next_head;
            eq_cnt <= next_eqcnt;
        end
    end

    // Bus control; pins settle through three stages before use
    always_comb
    begin
        next_pf = (sy1 & sy2) | (pf & (sy1 ^ sy2));
        next_st = st;
        next_pend = plot_pend | plot_cmd;
        // Our own attention drive must not look like a controller
        next_seen = atn_seen | (pf[0] && (st != CIC_SELF));
        next_pstart = 1'b0;
        next_pback = 1'b0;
        unique case (st)
            CIC_IDLE:
                if (plot_pend)
                begin
                    next_pend = plot_cmd;
                    next_pstart = !atn_seen;
                    next_st = atn_seen ? CIC_WAIT : CIC_SELF;
                end
            CIC_WAIT:
                if (pf[1])
                begin
                    next_st = CIC_PASS;
                    next_pstart = 1'b1;
                end
            CIC_SELF, CIC_PASS:
                if (plot_done)
                begin
                    next_st = CIC_IDLE;
                    next_pback = (st == CIC_PASS);
                end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sy0 <= 2'h0;
            sy1 <= 2'h0;
            sy2 <= 2'h0;
            pf <= 2'h0;
            st <= CIC_IDLE;
            plot_pend <= 1'b0;
            atn_seen <= 1'b0;
            plot_start <= 1'b0;
            pass_back <= 1'b0;
            cic <= 1'b0;
            atn_oe <= 1'b0;
            atn_out <= 1'b0;
        end
        else
        begin
            // Own drive masked; filter lag would echo it after release
            sy0 <= {talk_in, atn_in & ~atn_oe};
            sy1 <= sy0;
            sy2 <= sy1;
            pf <= next_pf;
            st <= next_st;
            plot_pend <= next_pend;
            atn_seen <= next_seen;
            plot_start <= next_pstart;
            pass_back <= next_pback;
            cic <= next_st[1];
            atn_oe <= (next_st == CIC_SELF);
            atn_out <= (next_st == CIC_SELF);
        end
    end

    srq_follow_a: assert property (ser[SE_FIRST_DETECTOR_SELECT] && see[SE_FIRST_DETECTOR_SELECT] |=> srq)
        else $error("service request missing");
    stall_hold_a: assert property (scan_stall && scan_active && !all_empty
        && !go_cmd |=> scan_stall)
        else $error("stall dropped early");
    nodata_err_a: assert property (nodata |=> esr[ES_QRY]
        && (eq_cnt != 3'h0))
        else $error("empty read not reported");
    esr_keep_a: assert property (esr[ES_CMD] && !(rd && (paddr == A_ESR))
        && !cls_cmd && !rst_cmd |=> esr[ES_CMD])
        else $error("error bit lost");
    replay_first_a: assert property (rp_cmd && !go_cmd
        |=> (rpv[0] == 15'h0000) && (cntv[0] == $past(nst)))
        else $error("replay not at first value");
    self_cic_a: assert property (st == CIC_IDLE && plot_pend && !atn_seen
        |=> cic && atn_oe && plot_start)
        else $error("control not taken");
    pass_back_a: assert property (st == CIC_PASS && plot_done
        |=> pass_back && !cic ##1 !pass_back)
        else $error("control not passed back");
    sync_last_a: assert property ($rose(ser[SE_LAST]) && ctrl[CT_SYNC]
        |-> $past(all_empty) && !scan_active)
        else $error("early last flag");
    block_len_a: assert property (q_cmd && !ovf && !qry_none && !rp_cmd
        && (bcnt != 15'h0000) && (bcnt <= cntv[sel])
        |=> blk == $past(bcnt))
        else $error("block length wrong");
endmodule
`default_nettype wire

// ### srro_ctrl_model.sv
// Process controller and plotter stand-in on the instrument bus
`timescale 1ns/1ps
`default_nettype none
module srro_ctrl_model
    import srro_pkg::*;
#(
    parameter int PLOT_DLY = 20
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic present,
    input wire logic cic,
    input wire logic plot_start,
    output logic ctl_atn,
    output logic talk_in,
    output logic plot_done
);
    logic [7:0] cnt;
    logic [7:0] pcnt;
    logic pbusy;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 8'h00;
            pcnt <= 8'h00;
            pbusy <= 1'b0;
            ctl_atn <= 1'b0;
            talk_in <= 1'b0;
            plot_done <= 1'b0;
        end
        else
        begin
            plot_done <= 1'b0;
            if (present && cnt < 8'h0C)
                cnt <= cnt + 8'h01;
            // Short attention burst shows a controller is on the bus
            ctl_atn <= present && cnt < 8'h04;
            // Addresses the device as talker until it takes control
            talk_in <= present && cnt >= 8'h04 && !cic;
            if (plot_start)
            begin
                pbusy <= 1'b1;
                pcnt <= 8'h00;
            end
            else if (pbusy)
            begin
                pcnt <= pcnt + 8'h01;
                if (pcnt == 8'(PLOT_DLY))
                begin
                    pbusy <= 1'b0;
                    plot_done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### srro_top_tb.sv
// Self-checking bench for the scan result raw output block
`timescale 1ns/1ps
`default_nettype none
module srro_top_tb
    import srro_pkg::*;
;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d;
        logic [31:0] e; logic s;} srro_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, dev_code;
    logic [31:0] pwdata, prdata, rd;
    logic meas_valid, scan_stall, scan_active, srq, dev_err, se;
    logic [15:0] meas_lvl1;
    logic atn_out, atn_oe, talk_in, plot_done, plot_start;
    logic pass_back, cic, ctl_atn, present;
    logic [1:0] mon;
    int err_total, cmp_count;
    logic [15:0] lv [4] = '{16'hFF9C, 16'h04E2, 16'h8000, 16'h7FFF};
    logic [3:0] els [3] = '{4'hB, 4'hD, 4'h9};
    srro_row_s rows [10] = '{
        '{1'b0, A_BCNT, 32'h0, 32'h64, 1'b0},
        '{1'b0, A_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b0, A_SEE, 32'h0, 32'h0, 1'b0},
        '{1'b1, A_BCNT, 32'h7531, 32'h0, 1'b0},
        '{1'b0, A_BCNT, 32'h0, 32'h64, 1'b0},
        '{1'b0, A_ESR, 32'h0, 32'h10, 1'b0},
        '{1'b0, A_ERR, 32'h0, 32'hFFFFFF22, 1'b0},
        '{1'b1, 8'h20, 32'h0, 32'h0, 1'b1},
        '{1'b0, A_ESR, 32'h0, 32'h20, 1'b0},
        '{1'b0, A_ERR, 32'h0, 32'hFFFFFF8F, 1'b0}};
    assign mon = {pass_back, cic};
    srro_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_valid(meas_valid),
        .meas_lvl1(meas_lvl1), .meas_lvl2(~meas_lvl1),
        .meas_vbyte(meas_lvl1[7:0]), .scan_stall(scan_stall),
        .scan_active(scan_active), .srq(srq), .dev_err(dev_err),
        .dev_code(dev_code), .atn_in(ctl_atn | (atn_oe & atn_out)),
        .atn_out(atn_out), .atn_oe(atn_oe), .talk_in(talk_in),
        .plot_done(plot_done), .plot_start(plot_start),
        .pass_back(pass_back), .cic(cic));
    srro_ctrl_model #(.PLOT_DLY(20)) ctl_u (.pclk(pclk),
        .presetn(presetn), .present(present), .cic(cic),
        .plot_start(plot_start), .ctl_atn(ctl_atn),
        .talk_in(talk_in), .plot_done(plot_done));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask
    // Wait-states are not assumed; the bound only catches a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            err_total++;
            test_done();
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdm(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk_word(rd & m, e);
    endtask
    task wt(input int k, input logic v);
        int n;
        n = 0;
        while (mon[k] !== v && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        if (mon[k] !== v)
        begin
            err_total++;
            test_done();
        end
    endtask
    task pulse_in(input logic m, input logic [15:0] v);
        @(posedge pclk);
        meas_valid <= m;
        dev_err <= !m;
        meas_lvl1 <= v;
        dev_code <= v[7:0];
        @(posedge pclk);
        meas_valid <= 1'b0;
        dev_err <= 1'b0;
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, meas_valid, dev_err} = 6'h00;
        {paddr, dev_code, pwdata, meas_lvl1, present} = 65'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (5) @(posedge pclk);
        chk_word({30'h0, pready, cic}, 32'h0);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                chk_word(rd, rows[i].e);
            chk_bit(se, rows[i].s);
        end
        apb(1'b1, A_SEE, 32'h80);
        apb(1'b1, A_BCNT, 32'h4);
        apb(1'b1, A_CMD, 32'h10);
        repeat (3) @(posedge pclk);
        foreach (lv[i])
            pulse_in(1'b1, lv[i]);
        repeat (5) @(posedge pclk);
        chk_bit(scan_stall, 1'b1);
        chk_bit(srq, 1'b1);
        rdm(A_SER, 32'h80, 32'h80);
        apb(1'b1, A_CMD, 32'h1);
        foreach (lv[i])
            rdm(A_DATA, {16'h0, lv[i]},
                32'hFFFFFFFF);
        apb(1'b1, A_CMD, 32'h20);
        repeat (3) @(posedge pclk);
        chk_bit(scan_stall, 1'b0);
        chk_bit(scan_active, 1'b0);
        rdm(A_DATA, 32'h0, 32'hFFFFFFFF);
        rdm(A_ESR, 32'h4, 32'h4);
        rdm(A_ERR, 32'hFFFFFE5C, 32'hFFFFFFFF);
        rdm(A_SER, 32'h4, 32'h4);
        rdm(A_SER, 32'h20, 32'hA4);
        apb(1'b1, A_CMD, 32'h2);
        repeat (2) @(posedge pclk);
        rdm(A_SER, 32'h80, 32'h80);
        apb(1'b1, A_CMD, 32'h1);
        rdm(A_DATA, {16'h0, lv[0]}, 32'hFFFFFFFF);
        pulse_in(1'b0, 16'h0005);
        rdm(A_ESR, 32'h8, 32'h8);
        rdm(A_ESR, 32'h0, 32'h8);
        rdm(A_ERR, 32'h5, 32'hFFFFFFFF);
        pulse_in(1'b0, 16'h0006);
        apb(1'b1, A_CMD, 32'h4);
        rdm(A_ESR, 32'h0, 32'h8);
        apb(1'b1, A_CTRL, 32'h9);
        apb(1'b1, A_BCNT, 32'h0);
        apb(1'b1, A_CMD, 32'h10);
        pulse_in(1'b1, lv[0]);
        pulse_in(1'b1, lv[1]);
        apb(1'b0, A_SER, 32'h0);
        rdm(A_SER, 32'h0, 32'hE0);
        apb(1'b1, A_CTRL, 32'hB);
        rdm(A_CTRL, 32'hB, 32'hF);
        apb(1'b1, A_CMD, 32'h20);
        rdm(A_SER, 32'hE0, 32'hE4);
        foreach (els[k])
        begin
            apb(1'b1, A_CTRL, {28'h0, els[k]});
            apb(1'b1, A_CMD, 32'h1);
            for (int i = 0; i < 2; i++)
                rdm(A_DATA, {16'h0, (k == 0) ? ~lv[i] : (k == 1)
                    ? {8'h0, lv[i][7:0]} : lv[i]},
                    32'hFFFFFFFF);
            rdm(A_SER, (k == 2) ? 32'h4 : 32'h0, 32'h4);
        end
        apb(1'b1, A_CMD, 32'h40);
        repeat (3) @(posedge pclk);
        chk_word({29'h0, cic, atn_oe, atn_out}, 32'h7);
        wt(0, 1'b0);
        chk_bit(atn_oe, 1'b0);
        present <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b1, A_CMD, 32'h40);
        wt(0, 1'b1);
        chk_bit(atn_oe, 1'b0);
        wt(1, 1'b1);
        @(posedge pclk);
        chk_bit(cic, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
